// ==== fsu_pkg.sv ====
// constants and types of the flash security-state unlock block
// assumes a single 100 MHz clock and AXI4-Lite register access
//
// Behaviour
// - security state is held in a register field and driven out to the chip
// - on the first clock after reset is released the security register loads from the stored security byte
// - a newly programmed security byte only takes effect after the next reset
// - four stored 16-bit words at the key addresses are the backdoor keys
// - verify-key command is accepted only while the key enable field is enabled
// - all four keys matching rewrites the security field to the unsecured code
// - verify-key command code 0x0C is accepted only in normal single-chip mode
package fsu_pkg;
  localparam logic [17:0] FSU_SEC_BYTE_ADDR  = 18'h3FF0F;
  localparam logic [17:0] FSU_KEY_BASE_ADDR  = 18'h3FF00;
  localparam logic [7:0]  FSU_CMD_VERIFY_KEY = 8'h0C;
  localparam logic [1:0]  FSU_SEC_UNSECURED  = 2'h2;
  localparam logic [1:0]  FSU_BACKDOOR_KEY_ENABLE_FIELD_ENABLED  = 2'h2;
  localparam int          FSU_SEC_LSB        = 0;
  localparam int          FSU_BACKDOOR_KEY_ENABLE_FIELD_LSB      = 6;
  // register byte offsets
  localparam logic [7:0]  FSU_OFS_SECCFG = 8'h00;
  localparam logic [7:0]  FSU_OFS_CMD    = 8'h04;
  localparam logic [7:0]  FSU_OFS_STAT   = 8'h08;
  localparam logic [7:0]  FSU_OFS_KEY01  = 8'h0C;
  localparam logic [7:0]  FSU_OFS_KEY23  = 8'h10;
  // status bits
  localparam int          FSU_ST_CCF     = 0;
  localparam int          FSU_ST_ACCERR  = 1;
  localparam logic [1:0]  FSU_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  FSU_RESP_SLVERR = 2'h2;
endpackage : fsu_pkg

// ==== fsu_unlock.sv ====
// flash security register, backdoor key verify and its AXI4-Lite slave
// assumes the nonvolatile array answers reads combinationally on nv_addr
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fsu_unlock
  import fsu_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // nonvolatile array read port
  output logic      [17:0] nv_addr,
  input  wire logic [15:0] nv_rdata,
  // chip mode and security outputs
  input  wire logic        special_mode,
  output logic             secured,
  output logic [7:0]       security_config_register,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_KEY, ST_DONE} fsu_state_t;

  fsu_state_t  st_q;
  logic [7:0]  sec_q;
  logic        ccf_q, accerr_q, boot_q;
  logic [7:0]  cmd_q;
  logic [15:0] key_q [4];
  logic [1:0]  idx_q;
  logic        match_q;
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  function automatic logic [15:0] fsu_merge(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] be);
    fsu_merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : fsu_merge

  // write channel capture; address and data may come in either order
  wire wr_go    = aw_q && w_q && !s_axi_bvalid;
  wire wr_cmd   = wr_go && awaddr_q == FSU_OFS_CMD;
  wire wr_stat  = wr_go && awaddr_q == FSU_OFS_STAT;
  wire wr_k01   = wr_go && awaddr_q == FSU_OFS_KEY01;
  wire wr_k23   = wr_go && awaddr_q == FSU_OFS_KEY23;
  wire wr_ok    = wr_go && (awaddr_q == FSU_OFS_SECCFG || awaddr_q == FSU_OFS_CMD ||
                            wr_stat || wr_k01 || wr_k23);
  // launch: software writes one to the complete bit while it is set
  wire launch   = wr_stat && wstrb_q[0] && wdata_q[FSU_ST_CCF] && ccf_q;
  wire [1:0] backdoor_key_enable_field = sec_q[FSU_BACKDOOR_KEY_ENABLE_FIELD_LSB +: 2];
  wire cmd_ok   = cmd_q == FSU_CMD_VERIFY_KEY && !special_mode
                  && backdoor_key_enable_field == FSU_BACKDOOR_KEY_ENABLE_FIELD_ENABLED;

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_arready = !s_axi_rvalid;
  assign nv_addr = (st_q == ST_BOOT) ? FSU_SEC_BYTE_ADDR
                 : FSU_KEY_BASE_ADDR + {15'h0, idx_q, 1'b0};
  assign secured = sec_q[FSU_SEC_LSB +: 2] != FSU_SEC_UNSECURED;
  assign security_config_register = sec_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'h0;
      w_q          <= 1'h0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= FSU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q     <= 1'h1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q     <= 1'h1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'h0;
        w_q          <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= wr_ok ? FSU_RESP_OKAY : FSU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= FSU_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= FSU_RESP_OKAY;
      if (s_axi_araddr == FSU_OFS_SECCFG) s_axi_rdata <= {24'h0, sec_q};
      else if (s_axi_araddr == FSU_OFS_CMD) s_axi_rdata <= {24'h0, cmd_q};
      else if (s_axi_araddr == FSU_OFS_STAT) s_axi_rdata <= {30'h0, accerr_q, ccf_q};
      else if (s_axi_araddr == FSU_OFS_KEY01) s_axi_rdata <= {key_q[1], key_q[0]};
      else if (s_axi_araddr == FSU_OFS_KEY23) s_axi_rdata <= {key_q[3], key_q[2]};
      else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= FSU_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // key registers and command code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= 8'h00;
      for (int i = 0; i < 4; i++) key_q[i] <= 16'h0;
    end else if (ccf_q) begin
      if (wr_cmd && wstrb_q[0]) cmd_q <= wdata_q[7:0];
      if (wr_k01) begin
        key_q[0] <= fsu_merge(key_q[0], wdata_q[15:0], wstrb_q[1:0]);
        key_q[1] <= fsu_merge(key_q[1], wdata_q[31:16], wstrb_q[3:2]);
      end
      if (wr_k23) begin
        key_q[2] <= fsu_merge(key_q[2], wdata_q[15:0], wstrb_q[1:0]);
        key_q[3] <= fsu_merge(key_q[3], wdata_q[31:16], wstrb_q[3:2]);
      end
    end
  end

  // boot load, then key compare sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= ST_BOOT;
      sec_q    <= 8'h00;
      ccf_q    <= 1'h0;
      accerr_q <= 1'h0;
      idx_q    <= 2'h0;
      match_q  <= 1'h1;
      boot_q   <= 1'h1;
    end else begin
      case (st_q)
        ST_BOOT: begin
          sec_q <= nv_rdata[7:0];
          ccf_q <= 1'b1;
          boot_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        ST_IDLE: begin
          if (launch) begin
            ccf_q <= 1'b0;
            idx_q <= 2'h0;
            match_q <= 1'b1;
            accerr_q <= !cmd_ok;
            st_q <= cmd_ok ? ST_KEY : ST_DONE;
          end else if (wr_stat && wstrb_q[0] && wdata_q[FSU_ST_ACCERR]) begin
            accerr_q <= 1'b0;
          end
        end
        ST_KEY: begin
          if (nv_rdata != key_q[idx_q]) match_q <= 1'b0;
          idx_q <= idx_q + 2'h1;
          if (idx_q == 2'h3) st_q <= ST_DONE;
        end
        default: begin
          if (accerr_q == 1'b0 && match_q)
            sec_q[FSU_SEC_LSB +: 2] <= FSU_SEC_UNSECURED;
          ccf_q <= 1'b1;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  a_boot_load: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ccf_q) && $past(boot_q) |-> sec_q == $past(nv_rdata[7:0]))
    else $error("security register not loaded from security byte");
  a_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_IDLE && launch && special_mode |=> st_q == ST_DONE && accerr_q)
    else $error("verify key accepted in special mode");
  a_code_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_IDLE && launch && cmd_q != FSU_CMD_VERIFY_KEY |=> accerr_q)
    else $error("unknown command code accepted");
  a_backdoor_key_enable_field_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_IDLE && launch && backdoor_key_enable_field != FSU_BACKDOOR_KEY_ENABLE_FIELD_ENABLED |=> accerr_q)
    else $error("verify key accepted while keys disabled");
  a_unlock_ok: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_DONE && !accerr_q && match_q |=> !secured)
    else $error("matching keys did not unsecure");
  a_mismatch_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_DONE && !match_q |=> $stable(sec_q))
    else $error("mismatched keys changed security state");
  a_sec_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q != ST_DONE && st_q != ST_BOOT |=> $stable(sec_q))
    else $error("security state changed outside reset or unlock");
  // busy after launch, complete again after the key walk and done cycle
  sequence s_busy_then_done;
    !ccf_q ##[1:5] ccf_q;
  endsequence
  a_cmd_done: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_IDLE && launch |=> s_busy_then_done)
    else $error("command complete flag not set again");
  a_key_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_KEY |-> nv_addr[17:3] == FSU_KEY_BASE_ADDR[17:3])
    else $error("key read outside key field");
endmodule : fsu_unlock
`default_nettype wire

// ==== fsu_nv_model.sv ====
// nonvolatile array stand-in: security byte and four backdoor keys
// assumes the block reads it combinationally through nv_addr
`timescale 1ns/1ps
`default_nettype none
module fsu_nv_model
  import fsu_pkg::*;
#(
  parameter logic [63:0] KEYS = 64'h4444_3333_2222_1111
)(
  // read port
  input  wire logic [17:0] nv_addr,
  output logic      [15:0] nv_rdata,
  // stored security byte
  input  wire logic [7:0]  sec_byte
);
  logic [17:0] ofs;
  assign ofs = nv_addr - FSU_KEY_BASE_ADDR;
  // unmapped words give a pattern that follows the address
  assign nv_rdata = (nv_addr == FSU_SEC_BYTE_ADDR) ? {8'h5A, sec_byte}
                  : (ofs < 18'h8) ? KEYS[{ofs[2:1], 4'h0} +: 16]
                  : ~nv_addr[15:0];
endmodule : fsu_nv_model
`default_nettype wire

// ==== fsu_tb.sv ====
// self-checking bench for the security unlock block
// assumes fsu_pkg and fsu_nv_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fsu_pkg::*;
  localparam logic [63:0] KEYS = 64'h4444_3333_2222_1111;
  logic aclk, aresetn, special_mode, secured;
  logic [17:0] nv_addr;
  logic [15:0] nv_rdata;
  logic [7:0] security_config_register, s_axi_awaddr, s_axi_araddr, sec_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int checked = 0;
  fsu_unlock dut (.aclk, .aresetn, .nv_addr, .nv_rdata, .special_mode, .secured,
    .security_config_register, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fsu_nv_model #(.KEYS(KEYS)) nv (.nv_addr, .nv_rdata, .sec_byte);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic summarize;
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_up(input int n);
    if (n >= 40) begin
      bad_count++;
      summarize();
    end
  endtask : give_up
  // one write (w=1) or one read, held until the answer is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    resp = w ? s_axi_bresp : s_axi_rresp;
    rdat = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    give_up(n);
  endtask : bus
  // load code and keys, clear the error, launch, then poll until complete
  task automatic launch(input logic [7:0] code, input logic [63:0] k);
    int n;
    bus(1'b1, FSU_OFS_CMD, {24'h0, code});
    bus(1'b1, FSU_OFS_KEY01, k[31:0]);
    bus(1'b1, FSU_OFS_KEY23, k[63:32]);
    bus(1'b1, FSU_OFS_STAT, 32'h2);
    bus(1'b1, FSU_OFS_STAT, 32'h1);
    chk("bresp_ok", FSU_RESP_OKAY, resp);
    for (n = 0; n < 40; n++) begin
      bus(1'b0, FSU_OFS_STAT, 32'h0);
      if (rdat[FSU_ST_CCF] === 1'b1) break;
    end
    give_up(n);
  endtask : launch
  task automatic rst;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : rst
  task automatic t_boot;
    chk("cfg", 8'h80, security_config_register);
    chk("secured", 1'b1, secured);
    bus(1'b0, FSU_OFS_SECCFG, 32'h0);
    chk("cfg_read", 32'h80, rdat);
    chk("rresp_ok", FSU_RESP_OKAY, resp);
  endtask : t_boot
  task automatic t_refused;
    launch(8'h01, KEYS);
    chk("err_code", 1'b1, rdat[FSU_ST_ACCERR]);
    special_mode <= 1'b1;
    launch(FSU_CMD_VERIFY_KEY, KEYS);
    chk("err_special", 1'b1, rdat[FSU_ST_ACCERR]);
    special_mode <= 1'b0;
    chk("secured_special", 1'b1, secured);
  endtask : t_refused
  task automatic t_mismatch;
    launch(FSU_CMD_VERIFY_KEY, KEYS ^ 64'h0001_0000_0000_0000);
    chk("err_mismatch", 1'b0, rdat[FSU_ST_ACCERR]);
    chk("secured_mismatch", 1'b1, secured);
    chk("cfg_mismatch", 8'h80, security_config_register);
    bus(1'b0, FSU_OFS_KEY23, 32'h0);
    chk("key23_stored", 32'h4445_3333, rdat);
  endtask : t_mismatch
  task automatic t_unlock;
    launch(FSU_CMD_VERIFY_KEY, KEYS);
    chk("secured_unlock", 1'b0, secured);
    chk("sec_field", FSU_SEC_UNSECURED, security_config_register[1:0]);
  endtask : t_unlock
  task automatic t_reload;
    sec_byte <= 8'h00;
    bus(1'b0, FSU_OFS_SECCFG, 32'h0);
    chk("no_early_load", 1'b0, secured);
    chk("no_early_cfg", 32'h82, rdat);
    rst();
    chk("cfg_reload", 8'h00, security_config_register);
    launch(FSU_CMD_VERIFY_KEY, KEYS);
    chk("err_backdoor_key_enable_field", 1'b1, rdat[FSU_ST_ACCERR]);
    chk("secured_backdoor_key_enable_field", 1'b1, secured);
  endtask : t_reload
  task automatic t_unmapped;
    bus(1'b0, 8'h20, 32'h0);
    chk("rresp", FSU_RESP_SLVERR, resp);
    bus(1'b1, 8'h24, 32'h1);
    chk("bresp", FSU_RESP_SLVERR, resp);
  endtask : t_unmapped
  initial begin
    {special_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    sec_byte = 8'h80;
    rst();
    t_boot();
    t_refused();
    t_mismatch();
    t_unlock();
    t_unmapped();
    t_reload();
    summarize();
  end
endmodule : testbench
`default_nettype wire
